// File: bench/ais_conv_model.sv
// Converter sequencer model: one sample start, then a done after a set latency
`timescale 1ns/100ps
module ais_conv_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Bench control
    input wire logic go_i,
    input wire logic [2:0] lat_i,
    // Towards the select block
    output logic sample_start_o,
    output logic conv_done_o
);
    logic busy_reg; // Conversion running
    logic [2:0] cnt_reg; // Cycles left; latency varies so slow answers get exercised
    // Never starts again before the running conversion ends
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_start_o <= 1'b0;
            conv_done_o <= 1'b0;
            busy_reg <= 1'b0;
            cnt_reg <= 3'h0;
        end else begin
            sample_start_o <= go_i && !busy_reg && !sample_start_o;
            conv_done_o <= 1'b0;
            if (sample_start_o) begin
                busy_reg <= 1'b1;
                cnt_reg <= lat_i;
            end else if (busy_reg && cnt_reg == 3'h0) begin
                busy_reg <= 1'b0;
                conv_done_o <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
        end
    end
endmodule : ais_conv_model

// File: bench/ais_input_select_props.sv
// Port-level assertions for the analog input select block
`timescale 1ns/100ps
module ais_input_select_props
    import ais_pkg::*;
#(
    parameter int NUM_INPUTS = 32,
    parameter bit SECOND_UNIT = 1'b0
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [15:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic avs_response_o,
    // Sequencing and routing
    input wire logic sample_start_i,
    input ais_routes_t routes_o,
    input wire logic slot_b_o,
    input wire logic wide_mode_o,
    // Addressing and pins
    input wire logic [7:0] words_per_input_o,
    input wire logic [12:0] scatter_offset_o,
    input wire logic scatter_mode_o,
    input wire logic [31:0] pin_digital_o,
    input wire logic [31:0] pin_read_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // A read completes in the cycle waitrequest is low
    wire rd_done = avs_read_i && !avs_waitrequest_o;
    // Every request waits exactly one cycle
    a_wait_first: assert property ((avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i)
        |-> avs_waitrequest_o) else $error("no wait cycle on new request");
    a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered after one wait");
    a_words_onehot: assert property ($onehot(words_per_input_o))
        else $error("buffer size not a power of two");
    a_pins_same: assert property (pin_digital_o == pin_read_en_o)
        else $error("pin read enable differs from digital mode");
    a_trio_wide: assert property (rd_done && avs_address_i == 4'h1 && wide_mode_o
        |-> avs_readdata_o == 16'h0000) else $error("trio register visible in wide mode");
    a_unmapped_zero: assert property (rd_done && avs_address_i > 4'h8
        |-> avs_readdata_o == 16'h0000 && avs_response_o) else $error("unmapped read wrong");
    a_offset_off: assert property (!scatter_mode_o |-> scatter_offset_o == 13'h0000)
        else $error("offset given outside scatter mode");
    // Routing and slot change only as a result of a sample start
    a_route_hold: assert property (!$past(sample_start_i)
        |-> $stable(routes_o) && $stable(slot_b_o)) else $error("routing moved without start");
endmodule : ais_input_select_props

bind ais_input_select ais_input_select_props #(.NUM_INPUTS(NUM_INPUTS),
    .SECOND_UNIT(SECOND_UNIT)) u_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .sample_start_i(sample_start_i), .routes_o(routes_o),
    .slot_b_o(slot_b_o), .wide_mode_o(wide_mode_o), .words_per_input_o(words_per_input_o),
    .scatter_offset_o(scatter_offset_o), .scatter_mode_o(scatter_mode_o),
    .pin_digital_o(pin_digital_o), .pin_read_en_o(pin_read_en_o));

// File: bench/tb_ais_input_select.sv
// Self-checking bench for the analog input select block
`timescale 1ns/100ps
`include "ais_map.svh"
module tb_ais_input_select
    import ais_pkg::*;
;
    logic clk_i, rst_b_i, avs_read_i, avs_write_i, go, avs_waitrequest_o, avs_response_o;
    logic sample_start_i, conv_done_i, slot_b_o, wide_mode_o, scatter_mode_o;
    logic [3:0] avs_address_i;
    logic [15:0] avs_writedata_i, avs_readdata_o, q;
    logic [1:0] avs_byteenable_i;
    logic [2:0] lat;
    ais_routes_t routes_o;
    logic [7:0] words_per_input_o;
    logic [12:0] scatter_offset_o;
    logic [31:0] pin_digital_o, pin_read_en_o, v;
    // Second input select instance: only the pins, read data and routing are watched
    logic [15:0] q2, rd2;
    logic [31:0] pin2;
    ais_routes_t rt2;
    int n_errors, comparisons, i;
    // Writable masks and the expected scan order
    logic [15:0] msk[8] = '{`AIS_MSK_BUFLOC, `AIS_MSK_TRIO, `AIS_MSK_FIRST, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, `AIS_MSK_MODE};
    int seq[$] = '{2, 5, 16, 2};
    ais_input_select u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .sample_start_i(sample_start_i), .conv_done_i(conv_done_i), .routes_o(routes_o),
        .slot_b_o(slot_b_o), .wide_mode_o(wide_mode_o), .words_per_input_o(words_per_input_o),
        .scatter_offset_o(scatter_offset_o), .scatter_mode_o(scatter_mode_o),
        .pin_digital_o(pin_digital_o), .pin_read_en_o(pin_read_en_o));
    ais_input_select #(.NUM_INPUTS(32), .SECOND_UNIT(1'b1)) u_dut2 (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(rd2), .avs_waitrequest_o(),
        .avs_response_o(), .sample_start_i(sample_start_i), .conv_done_i(conv_done_i),
        .routes_o(rt2), .slot_b_o(), .wide_mode_o(), .words_per_input_o(),
        .scatter_offset_o(), .scatter_mode_o(), .pin_digital_o(pin2), .pin_read_en_o());
    ais_conv_model u_conv (.clk_i(clk_i), .rst_b_i(rst_b_i), .go_i(go), .lat_i(lat),
        .sample_start_o(sample_start_i), .conv_done_o(conv_done_i));
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; waitrequest and read data taken at the rising edge itself
    task bus(input bit w, input int a, input int d);
        int t;
        avs_address_i <= 4'(a);
        avs_writedata_i <= 16'(d);
        avs_write_i <= w;
        avs_read_i <= !w;
        t = 0;
        do begin @(posedge clk_i); t++; end while (avs_waitrequest_o !== 1'b0 && t < 20);
        q = avs_readdata_o;
        q2 = rd2;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
        if (t >= 20) chk(0, 1);
    endtask : bus
    // One sample and conversion with a random latency
    task samp();
        int t;
        lat <= 3'($urandom % 6);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        t = 0;
        do begin @(negedge clk_i); t++; end while (conv_done_i !== 1'b1 && t < 40);
        @(posedge clk_i);
        if (t >= 40) chk(0, 1);
    endtask : samp
    // Channels 1 to 3 against the positive bit and negative code
    task trio(input bit p, input bit [1:0] n);
        ais_route_t r;
        for (int k = 1; k < 4; k++) begin
            r = routes_o[k*12 +: 12];
            chk({r.pos_ref, r.pos_idx}, (p ? 3 : 0) + k - 1);
            chk(r.neg_ref, !n[1]);
            if (n[1]) chk(r.neg_idx, (n[0] ? 9 : 6) + k - 1);
        end
    endtask : trio
    // Channel 0 and the slot in use
    task ch0(input bit s, input bit [4:0] p, input bit n);
        chk(slot_b_o, s);
        chk({routes_o.ch0.pos_ref, routes_o.ch0.pos_idx}, p);
        chk(routes_o.ch0.neg_ref, !n);
        if (n) chk(routes_o.ch0.neg_idx, 1);
    endtask : ch0
    task end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #50000;
        n_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        {rst_b_i, avs_read_i, avs_write_i, go, avs_address_i, avs_writedata_i} = '0;
        avs_byteenable_i = 2'b11;
        lat = 3'h1;
        n_errors = 0;
        comparisons = 0;
        void'($urandom(32'he0f1));
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (i = 0; i < 8; i++) begin bus(0, i, 0); chk(q, 0); end
        for (i = 0; i < 8; i++) begin
            v = $urandom;
            bus(1, i, v[15:0]);
            bus(0, i, 0);
            chk(q, v[15:0] & msk[i]);
        end
        bus(0, 5, 0); chk(q2, 0);
        for (i = 9; i < 16; i++) begin bus(0, i, 0); chk({avs_response_o, q}, 17'h10000); end
        bus(1, 7, 0);
        for (i = 0; i < 8; i++) begin bus(1, 0, i); chk(words_per_input_o, 1 << i); end
        v = $urandom;
        bus(1, 6, v[15:0]);
        bus(1, 5, v[31:16]);
        chk(pin_digital_o, v);
        chk(pin2, {16'hffff, v[15:0]});
        bus(1, 7, 16'h0010);
        chk(pin_digital_o, 32'hffffffff);
        bus(1, 7, 0);
        for (i = 0; i < 8; i++) begin bus(1, 1, i); samp(); trio(i[0], i[2:1]); end
        // Alternation: slot A fields first, slot B fields next
        v = $urandom;
        bus(1, 1, v[15:0]);
        bus(1, 2, v[15:0]);
        bus(1, 7, 16'h0002);
        samp(); ch0(0, v[4:0], v[7]); trio(v[0], v[2:1]);
        samp(); ch0(1, v[12:8], v[15]); trio(v[8], v[10:9]);
        // Wide mode hides and freezes the trio register
        bus(1, 7, 16'h0001);
        chk(wide_mode_o, 1);
        bus(0, 1, 0); chk(q, 0);
        bus(1, 1, 16'h0707);
        bus(1, 7, 0);
        bus(0, 1, 0); chk(q, v[15:0] & 16'h0707);
        // Scan visits enabled inputs, lowest first, then wraps
        bus(1, 3, 16'h0001);
        bus(1, 4, 16'h0024);
        bus(1, 7, 16'h0004);
        foreach (seq[j]) begin
            samp();
            chk(routes_o.ch0.pos_idx, seq[j]);
            chk(rt2.ch0.pos_ref, seq[j] >= 16);
        end
        // Scatter offset is the input index scaled by the buffer size
        bus(1, 7, 0);
        bus(1, 2, 16'h0005);
        bus(1, 0, 3);
        samp();
        chk({scatter_mode_o, scatter_offset_o}, 14'h2028);
        bus(1, 7, 16'h0008);
        chk({scatter_mode_o, scatter_offset_o}, 0);
        end_of_test();
    end
endmodule : tb_ais_input_select

// File: src/ais_input_select.sv
// Analog input select, scan mask and pin configuration logic
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "ais_map.svh"

// How it works
// - Buffer code n gives 2^n words per input
// - Trio negative code 11/10/0x picks inputs or reference
// - Slot A trio negative at bits 2-1
// - Trio positive bit picks 3-5 or 0-2
// - Wide mode hides trio fields, reads zero
// - First negative bit picks input 1 or reference
// - First positive code picks that input index
// - Slot B first positive at bits 12-8
// - Second instance limits first positive to 0-15
// - Scan bits include inputs, high/low halves
// - Scan bits writable; absent inputs convert reference
// - Pin bit one means digital, zero analog
// - Absent pin bits stored but have no effect
// - Second instance has no high pin register
// - Module disabled forces all pins digital
// - Alternate mode toggles slot A then B
// - Scan mode steps slot A first positive through mask
// - Wide bit selects single channel operation
// - Buffer size scales offset only in scatter/gather order
module ais_input_select
    import ais_pkg::*;
#(
    parameter int NUM_INPUTS = 32,
    parameter bit SECOND_UNIT = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [15:0] avs_writedata_i,
    input wire logic [1:0] avs_byteenable_i,
    output logic [15:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic avs_response_o,
    // Converter sequencing
    input wire logic sample_start_i,
    input wire logic conv_done_i,
    // Routing to the multiplexer
    output ais_routes_t routes_o,
    output logic slot_b_o,
    output logic wide_mode_o,
    // Transfer addressing
    output logic [7:0] words_per_input_o,
    output logic [12:0] scatter_offset_o,
    output logic scatter_mode_o,
    // Port pins
    output logic [31:0] pin_digital_o,
    output logic [31:0] pin_read_en_o
);

    // Registers as software sees them
    logic [15:0] bufloc_reg;
    logic [15:0] trio_reg;
    logic [15:0] first_reg;
    logic [15:0] scanh_reg;
    logic [15:0] scanl_reg;
    logic [15:0] pinh_reg;
    logic [15:0] pinl_reg;
    logic [15:0] mode_reg;
    // Read data and bus phase
    logic [15:0] rdata_reg;
    logic resp_reg;
    logic ack_reg;
    // Sample state
    ais_state_t state_reg;
    ais_slot_t slot_reg;
    logic [4:0] scan_idx_reg;
    ais_routes_t routes_reg;
    logic slot_b_reg;
    logic [4:0] active_in_reg;

    // Byte-lane merge of a write into a register under a writable mask
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be, input logic [15:0] msk);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}};
        merge = ((old & ~lanes) | (wd & lanes)) & msk;
    endfunction : merge

    // Next enabled scan input after cur, wrapping; cur itself when mask empty
    function automatic logic [4:0] next_scan(input logic [31:0] msk, input logic [4:0] cur);
        logic [4:0] cand;
        next_scan = cur;
        for (int k = 32; k >= 1; k--) begin
            cand = 5'(cur + 5'(k));
            if (msk[cand]) begin
                next_scan = cand;
            end
        end
    endfunction : next_scan

    // Route a trio channel (offset 0..2 for ch1..ch3)
    function automatic ais_route_t trio_route(input logic pos, input logic [1:0] neg,
                                              input logic [4:0] ofs);
        trio_route.pos_idx = pos ? 5'(5'h03 + ofs) : ofs;
        trio_route.pos_ref = 1'b0;
        trio_route.neg_idx = neg[0] ? 5'(5'h09 + ofs) : 5'(5'h06 + ofs);
        trio_route.neg_ref = ~neg[1];
    endfunction : trio_route

    // Decoded mode bits
    wire logic wide_w = mode_reg[`AIS_MODE_WIDE];
    wire logic alt_w = mode_reg[`AIS_MODE_ALT];
    wire logic scan_w = mode_reg[`AIS_MODE_SCAN];
    wire logic disable_w = mode_reg[`AIS_MODE_DIS];
    wire logic [31:0] scan_mask_w = {scanh_reg, scanl_reg};
    wire logic [31:0] pin_cfg_w = {pinh_reg, pinl_reg};

    // Bus decode; second unit has no high pin register
    wire logic req_w = (avs_read_i | avs_write_i) & ~ack_reg;
    wire logic pinh_hit_w = (avs_address_i == `AIS_OFS_PINH) & ~SECOND_UNIT;
    wire logic wr_w = avs_write_i & req_w;
    wire logic known_w = (avs_address_i <= `AIS_OFS_STAT) &
                         ((avs_address_i != `AIS_OFS_PINH) | pinh_hit_w);

    // Trio fields read as zero in wide mode
    wire logic [15:0] trio_view_w = wide_w ? `AIS_ZERO_PAD : trio_reg;

    // Read mux
    logic [15:0] rmux_w;
    always_comb begin
        case (avs_address_i)
            `AIS_OFS_BUFLOC: rmux_w = bufloc_reg;
            `AIS_OFS_TRIO: rmux_w = trio_view_w;
            `AIS_OFS_FIRST: rmux_w = first_reg;
            `AIS_OFS_SCANH: rmux_w = scanh_reg;
            `AIS_OFS_SCANL: rmux_w = scanl_reg;
            `AIS_OFS_PINH: rmux_w = pinh_hit_w ? pinh_reg : `AIS_ZERO_PAD;
            `AIS_OFS_PINL: rmux_w = pinl_reg;
            `AIS_OFS_MODE: rmux_w = mode_reg;
            `AIS_OFS_STAT: rmux_w = {3'h0, active_in_reg, 6'h00, slot_b_reg,
                                     (state_reg == AIS_CONV)};
            default: rmux_w = `AIS_ZERO_PAD;
        endcase
    end

    // One wait cycle per access, then answer
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
    assign avs_readdata_o = rdata_reg;
    assign avs_response_o = resp_reg;

    // Bus phase and read capture
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= `AIS_RST_VAL;
            resp_reg <= 1'b0;
        end else begin
            ack_reg <= req_w;
            if (req_w) begin
                rdata_reg <= avs_read_i ? rmux_w : `AIS_ZERO_PAD;
                resp_reg <= ~known_w;
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bufloc_reg <= `AIS_RST_VAL;
            trio_reg <= `AIS_RST_VAL;
            first_reg <= `AIS_RST_VAL;
            scanh_reg <= `AIS_RST_VAL;
            scanl_reg <= `AIS_RST_VAL;
            pinh_reg <= `AIS_RST_VAL;
            pinl_reg <= `AIS_RST_VAL;
            mode_reg <= `AIS_RST_VAL;
        end else if (wr_w) begin
            case (avs_address_i)
                `AIS_OFS_BUFLOC: bufloc_reg <= merge(bufloc_reg, avs_writedata_i,
                                                     avs_byteenable_i, `AIS_MSK_BUFLOC);
                // Trio writes ignored in wide mode where the field is absent
                `AIS_OFS_TRIO: if (!wide_w) begin
                    trio_reg <= merge(trio_reg, avs_writedata_i, avs_byteenable_i,
                                      `AIS_MSK_TRIO);
                end
                `AIS_OFS_FIRST: first_reg <= merge(first_reg, avs_writedata_i,
                                                   avs_byteenable_i, `AIS_MSK_FIRST);
                `AIS_OFS_SCANH: scanh_reg <= merge(scanh_reg, avs_writedata_i,
                                                   avs_byteenable_i, 16'hffff);
                `AIS_OFS_SCANL: scanl_reg <= merge(scanl_reg, avs_writedata_i,
                                                   avs_byteenable_i, 16'hffff);
                `AIS_OFS_PINH: if (pinh_hit_w) begin
                    pinh_reg <= merge(pinh_reg, avs_writedata_i, avs_byteenable_i,
                                      16'hffff);
                end
                `AIS_OFS_PINL: pinl_reg <= merge(pinl_reg, avs_writedata_i,
                                                 avs_byteenable_i, 16'hffff);
                `AIS_OFS_MODE: mode_reg <= merge(mode_reg, avs_writedata_i,
                                                 avs_byteenable_i, `AIS_MSK_MODE);
                default: ;
            endcase
        end
    end

    // Slot in use for the sample about to start
    wire ais_slot_t use_slot_w = (alt_w && slot_reg == AIS_SLOT_B) ? AIS_SLOT_B
                                                                   : AIS_SLOT_A;
    wire logic use_b_w = (use_slot_w == AIS_SLOT_B);
    // Scan only steps slot A channel 0 positive
    wire logic scanning_w = scan_w & ~use_b_w;
    wire logic [4:0] first_pos_sel_w = use_b_w ? first_reg[`AIS_FIRST_POS_B]
                                               : first_reg[`AIS_FIRST_POS_A];
    wire logic [4:0] scan_pick_w = next_scan(scan_mask_w, scan_idx_reg);
    wire logic [4:0] ch0_pos_w = scanning_w ? scan_pick_w : first_pos_sel_w;
    // Inputs beyond the present count, or above 15 on the second unit, convert reference
    wire logic ch0_absent_w = (32'(ch0_pos_w) >= NUM_INPUTS) |
                              (SECOND_UNIT & ch0_pos_w[4]);
    wire logic ch0_neg_w = use_b_w ? first_reg[`AIS_FIRST_NEG_B]
                                   : first_reg[`AIS_FIRST_NEG_A];
    wire logic trio_pos_w = use_b_w ? trio_reg[`AIS_TRIO_POS_B] : trio_reg[`AIS_TRIO_POS_A];
    wire logic [1:0] trio_neg_w = use_b_w ? trio_reg[`AIS_TRIO_NEG_B]
                                          : trio_reg[`AIS_TRIO_NEG_A];

    // Routes assembled for the coming sample
    ais_routes_t routes_next;
    always_comb begin
        routes_next.ch0.pos_idx = ch0_pos_w;
        routes_next.ch0.pos_ref = ch0_absent_w;
        routes_next.ch0.neg_idx = 5'h01;
        routes_next.ch0.neg_ref = ~ch0_neg_w;
        routes_next.ch1 = trio_route(trio_pos_w, trio_neg_w, 5'h00);
        routes_next.ch2 = trio_route(trio_pos_w, trio_neg_w, 5'h01);
        routes_next.ch3 = trio_route(trio_pos_w, trio_neg_w, 5'h02);
    end

    // Sample sequencer; routing is latched only at a sample start
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= AIS_IDLE;
            slot_reg <= AIS_SLOT_A;
            scan_idx_reg <= 5'h1f;
            routes_reg <= '0;
            slot_b_reg <= 1'b0;
            active_in_reg <= 5'h00;
        end else begin
            case (state_reg)
                AIS_IDLE: if (sample_start_i) begin
                    routes_reg <= routes_next;
                    slot_b_reg <= use_b_w;
                    active_in_reg <= ch0_pos_w;
                    slot_reg <= (alt_w && !use_b_w) ? AIS_SLOT_B : AIS_SLOT_A;
                    if (scanning_w) begin
                        scan_idx_reg <= scan_pick_w;
                    end
                    state_reg <= AIS_CONV;
                end
                // Conversion in progress holds the routing steady
                AIS_CONV: if (conv_done_i) begin
                    state_reg <= AIS_IDLE;
                end
                default: state_reg <= AIS_IDLE;
            endcase
        end
    end

    // Routing outputs; trio channels unused in wide mode
    assign routes_o = routes_reg;
    assign slot_b_o = slot_b_reg;
    assign wide_mode_o = wide_w;

    // Buffer sizing and scatter address
    assign words_per_input_o = 8'(8'h01 << bufloc_reg[2:0]);
    assign scatter_mode_o = ~mode_reg[`AIS_MODE_ORDER];
    assign scatter_offset_o = scatter_mode_o ?
                              13'(13'(active_in_reg) << bufloc_reg[2:0]) : 13'h0000;

    // Pin modes; absent inputs and the disabled module force digital
    logic [31:0] pin_next;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (disable_w || i >= NUM_INPUTS || (SECOND_UNIT && i >= 16)) begin
                pin_next[i] = 1'b1;
            end else begin
                pin_next[i] = pin_cfg_w[i];
            end
        end
    end
    assign pin_digital_o = pin_next;
    assign pin_read_en_o = pin_next;

endmodule : ais_input_select

// File: src/ais_map.svh
// Register offsets, field positions and reset values for the input select block
`ifndef AIS_MAP_SVH
`define AIS_MAP_SVH
// Word offsets of the 16-bit registers on the Avalon-MM slave, one address apart
`define AIS_OFS_BUFLOC 4'h0
`define AIS_OFS_TRIO 4'h1
`define AIS_OFS_FIRST 4'h2
`define AIS_OFS_SCANH 4'h3
`define AIS_OFS_SCANL 4'h4
`define AIS_OFS_PINH 4'h5
`define AIS_OFS_PINL 4'h6
`define AIS_OFS_MODE 4'h7
`define AIS_OFS_STAT 4'h8
// Writable masks per register
`define AIS_MSK_BUFLOC 16'h0007
`define AIS_MSK_TRIO 16'h0707
`define AIS_MSK_FIRST 16'h9f9f
`define AIS_MSK_MODE 16'h001f
// Mode register bit positions
`define AIS_MODE_WIDE 0
`define AIS_MODE_ALT 1
`define AIS_MODE_SCAN 2
`define AIS_MODE_ORDER 3
`define AIS_MODE_DIS 4
// Field positions
`define AIS_TRIO_POS_A 0
`define AIS_TRIO_NEG_A 2:1
`define AIS_TRIO_POS_B 8
`define AIS_TRIO_NEG_B 10:9
`define AIS_FIRST_POS_A 4:0
`define AIS_FIRST_NEG_A 7
`define AIS_FIRST_POS_B 12:8
`define AIS_FIRST_NEG_B 15
`define AIS_RST_VAL 16'h0000
`define AIS_ZERO_PAD 16'h0000
`endif

// File: src/ais_pkg.sv
// Types for the analog input select block
package ais_pkg;
    // One sample/hold channel routing: input index, or reference when ref set
    typedef struct packed {
        logic [4:0] pos_idx;
        logic pos_ref;
        logic [4:0] neg_idx;
        logic neg_ref;
    } ais_route_t;
    // Four channels routed at once
    typedef struct packed {
        ais_route_t ch3;
        ais_route_t ch2;
        ais_route_t ch1;
        ais_route_t ch0;
    } ais_routes_t;
    // Sample slot in use
    typedef enum logic {AIS_SLOT_A, AIS_SLOT_B} ais_slot_t;
    // Sequencer states
    typedef enum logic [1:0] {AIS_IDLE, AIS_CONV} ais_state_t;
endpackage : ais_pkg
